// ==== inc/cfc_pkg.sv ====
// package: register layout, reset values and operation codes for the flag/control block
package cfc_pkg;

   // ***************************************************
   // register addresses (word index on the plain port)
   // ***************************************************
   localparam logic [1:0] ADDR_FLAG_WORD  = 2'h0;
   localparam logic [1:0] ADDR_CFG_WORD   = 2'h1;
   localparam logic [1:0] ADDR_INT_CTRL   = 2'h2;

   // ***************************************************
   // flag word bit positions
   // ***************************************************
   localparam int FW_GUARD_A   = 15;
   localparam int FW_GUARD_B   = 14;
   localparam int FW_CLIP_A    = 13;
   localparam int FW_CLIP_B    = 12;
   localparam int FW_ANY_GUARD = 11;
   localparam int FW_ANY_CLIP  = 10;
   localparam int FW_DO_RUN    = 9;
   localparam int FW_HALF_C    = 8;
   localparam int FW_PRIO_LO   = 5;
   localparam int FW_REP_RUN   = 4;
   localparam int FW_NEG       = 3;
   localparam int FW_SIGN_CHG  = 2;
   localparam int FW_ZERO      = 1;
   localparam int FW_CARRY     = 0;

   // ***************************************************
   // config word and interrupt control bit positions
   // ***************************************************
   localparam int CW_MUL_US    = 12;
   localparam int CW_EARLY     = 11;
   localparam int CW_DEPTH_LO  = 8;
   localparam int CW_CLIP_A    = 7;
   localparam int CW_CLIP_B    = 6;
   localparam int CW_STORE     = 5;
   localparam int CW_WIDTH     = 4;
   localparam int CW_PRIO_MSB  = 3;
   localparam int CW_PROG_WIN  = 2;
   localparam int CW_ROUND     = 1;
   localparam int CW_INT_MODE  = 0;
   localparam int IC_NEST_DIS  = 15;

   // ***************************************************
   // reset values and priority mask
   // ***************************************************
   localparam logic [15:0] FLAG_WORD_RST  = 16'h0000;
   localparam logic [15:0] CFG_WORD_RST   = 16'h0020;
   localparam logic [15:0] INT_CTRL_RST   = 16'h0000;
   localparam logic [2:0]  PRIO_ALL_MASK  = 3'h7;

   // ***************************************************
   // alu operations and multiply forms
   // ***************************************************
   typedef enum logic [2:0] {
      CFC_OP_ADD,
      CFC_OP_SUB,
      CFC_OP_AND,
      CFC_OP_OR,
      CFC_OP_XOR,
      CFC_OP_SHL,
      CFC_OP_SHR,
      CFC_OP_ASR
   } cfc_op_t;

   typedef enum logic [2:0] {
      CFC_MUL_SS,
      CFC_MUL_UU,
      CFC_MUL_US,
      CFC_MUL_SU,
      CFC_MUL_SLIT,
      CFC_MUL_ULIT,
      CFC_MUL_BYTE
   } cfc_mul_t;

   typedef struct packed {
      logic        valid;
      cfc_op_t     op;
      logic        byte_mode;
      logic [15:0] a;
      logic [15:0] b;
   } cfc_alu_req_t;

   typedef struct packed {
      logic [15:0] result;
      logic        carry;
      logic        half_carry;
      logic        neg;
      logic        sign_chg;
      logic        zero;
   } cfc_alu_res_t;

   typedef struct packed {
      logic valid;
      logic guard_a;
      logic guard_b;
      logic clip_a;
      logic clip_b;
   } cfc_acc_evt_t;

endpackage : cfc_pkg

// ==== core/cfc_alu.sv ====
// 16-bit alu datapath: result and flag terms, byte or word width
`timescale 1ns/1ps
module cfc_alu
   import cfc_pkg::*;
(
   input  wire cfc_alu_req_t req_i,
   output cfc_alu_res_t      res_o
);

   // ***************************************************
   // byte/word operand shaping
   // ***************************************************
   wire [15:0] a_w   = req_i.byte_mode ? {8'h00, req_i.a[7:0]} : req_i.a;
   wire [15:0] b_w   = req_i.byte_mode ? {8'h00, req_i.b[7:0]} : req_i.b;
   wire        is_sub = (req_i.op == CFC_OP_SUB);
   wire [15:0] b_eff = is_sub ? ~b_w : b_w;
   wire        cin    = is_sub;
   wire [16:0] sum    = {1'b0, a_w} + {1'b0, b_eff} + {16'h0000, cin};
   wire [8:0]  sum_lo = {1'b0, a_w[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
   wire [4:0]  nib    = {1'b0, a_w[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
   wire        arith  = (req_i.op == CFC_OP_ADD) || is_sub;
   wire        msb_i  = req_i.byte_mode ? 1'b1 : 1'b0;

   logic [15:0] r;
   logic        c;
   always_comb
   begin
      r = 16'h0000;
      c = 1'b0;
      case (req_i.op)
         CFC_OP_ADD, CFC_OP_SUB:
         begin
            r = sum[15:0];
            c = req_i.byte_mode ? sum_lo[8] : sum[16]; // [RL11]
         end
         CFC_OP_AND: r = a_w & b_w;
         CFC_OP_OR:  r = a_w | b_w;
         CFC_OP_XOR: r = a_w ^ b_w;
         CFC_OP_SHL:
         begin
            r = {a_w[14:0], 1'b0};
            c = req_i.byte_mode ? a_w[7] : a_w[15];
         end
         CFC_OP_SHR:
         begin
            r = {1'b0, a_w[15:1]};
            c = a_w[0];
         end
         CFC_OP_ASR:
         begin
            r = req_i.byte_mode ? {8'h00, a_w[7], a_w[7:1]} : {a_w[15], a_w[15:1]};
            c = a_w[0];
         end
         default: r = 16'h0000;
      endcase
   end

   // ***************************************************
   // flag terms; carry acts as not-borrow on subtract
   // ***************************************************
   wire [15:0] r_sz  = req_i.byte_mode ? {8'h00, r[7:0]} : r; // [RL21]
   wire        sgn_r = msb_i ? r[7] : r[15];
   wire        sgn_a = msb_i ? a_w[7] : a_w[15];
   wire        sgn_b = msb_i ? b_eff[7] : b_eff[15];
   assign res_o.result     = r_sz;
   assign res_o.carry      = c; // [RL11]
   assign res_o.half_carry = arith & (req_i.byte_mode ? nib[4] : sum_lo[8]); // [RL5]
   assign res_o.neg        = sgn_r; // [RL8]
   assign res_o.sign_chg   = arith & (sgn_a == sgn_b) & (sgn_r != sgn_a); // [RL9]
   assign res_o.zero       = (r_sz == 16'h0000);

endmodule : cfc_alu

// ==== core/cfc_core.sv ====
// cpu flag word, core config word, alu flag update and multiplier
//
// Behaviour
// RL1 - guard flags bits 15/14 follow accumulator overflow; bit 11 reads their OR
// RL2 - clip flags bits 13/12 are sticky; software may clear, never set
// RL3 - bit 10 reads OR of clip flags; clearing it clears both
// RL4 - bit 9 shows DO loop running, bit 4 shows REPEAT running
// RL5 - half carry from bit 4 (byte) or bit 8 (word)
// RL6 - priority is config bit 3 over bits 7-5; msb or 111 masks user interrupts
// RL7 - priority bits are read-only while nesting disable is set
// RL8 - negative flag bit 3 follows result sign
// RL9 - bit 2 flags signed overflow
// RL10 - zero flag bit 1 cleared by nonzero result of a zero-affecting op
// RL11 - carry bit 0 from result msb; carry flags act as not-borrow on subtract
// RL12 - config bit 12 selects unsigned multiply
// RL13 - writing 1 to config bit 11 ends DO loop; reads as zero
// RL14 - config bits 10-8 report active DO loop count
// RL15 - config bits 7/6 enable accumulator A/B saturation
// RL16 - config bit 5 enables store saturation, reset value 1
// RL17 - config bit 4 selects 9.31 or 1.31 saturation width
// RL18 - config bit 2 maps program space into data window
// RL19 - config bit 1 selects biased rounding, else convergent
// RL20 - config bit 0 selects integer multiply, else fractional
// RL21 - 16-bit alu with add, subtract, shift, logic at byte or word width
// RL22 - shared 17x17 multiplier serves all mcu multiply forms
// RL23 - alu flag update wins over a same-cycle write; clear-only bits never set
`timescale 1ns/1ps
module cfc_core
   import cfc_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [1:0]   addr_i,
   input  wire logic [15:0]  wdata_i,
   input  wire logic         wr_i,
   input  wire logic         rd_i,
   output logic [15:0]       rdata_o,
   input  wire cfc_alu_req_t alu_req_i,
   output cfc_alu_res_t      alu_res_o,
   input  wire cfc_acc_evt_t acc_evt_i,
   input  wire logic         do_running_i,
   input  wire logic         rep_running_i,
   input  wire logic [2:0]   loop_nest_depth_i,
   input  wire logic         mul_valid_i,
   input  wire cfc_mul_t     mul_form_i,
   input  wire logic [15:0]  mul_a_i,
   input  wire logic [15:0]  mul_b_i,
   output logic [31:0]       mul_prod_o,
   output logic              early_loop_exit_o,
   output logic              user_irq_masked_o,
   output logic [3:0]        cpu_priority_level_o,
   output logic              mult_unsigned_sel_o,
   output logic              acc_a_clip_enable_o,
   output logic              acc_b_clip_enable_o,
   output logic              store_clip_enable_o,
   output logic              clip_width_select_o,
   output logic              program_window_enable_o,
   output logic              rounding_select_o,
   output logic              int_mode_o
);

   // ***************************************************
   // state
   // ***************************************************
   logic        guard_a_q, guard_b_q, clip_a_q, clip_b_q;
   logic        half_c_q, neg_q, sign_chg_q, zero_q, carry_q;
   logic [2:0]  prio_q;
   logic [15:0] cfg_q;
   logic [15:0] ictl_q;
   logic        early_q;
   logic [15:0] rdata_q;
   logic [31:0] prod_q;

   // ***************************************************
   // alu
   // ***************************************************
   cfc_alu u_alu (
      .req_i (alu_req_i),
      .res_o (alu_res_o)
   );

   // ***************************************************
   // decode
   // ***************************************************
   wire wr_flag = wr_i && (addr_i == ADDR_FLAG_WORD);
   wire wr_cfg  = wr_i && (addr_i == ADDR_CFG_WORD);
   wire wr_ictl = wr_i && (addr_i == ADDR_INT_CTRL);
   wire nest_dis = ictl_q[IC_NEST_DIS];
   wire alu_upd  = alu_req_i.valid;
   wire early_req = wr_cfg && wdata_i[CW_EARLY]; // [RL13]

   wire clr_any_clip = wr_flag && !wdata_i[FW_ANY_CLIP]; // [RL3]
   wire clr_clip_a   = wr_flag && (!wdata_i[FW_CLIP_A] || !wdata_i[FW_ANY_CLIP]);
   wire clr_clip_b   = wr_flag && (!wdata_i[FW_CLIP_B] || !wdata_i[FW_ANY_CLIP]);

   wire [15:0] flag_word = {guard_a_q, guard_b_q, clip_a_q, clip_b_q,
                            guard_a_q | guard_b_q, clip_a_q | clip_b_q, // [RL1] [RL3]
                            do_running_i, half_c_q, prio_q, rep_running_i, // [RL4]
                            neg_q, sign_chg_q, zero_q, carry_q};
   wire [15:0] cfg_word  = {3'h0, cfg_q[CW_MUL_US], 1'b0, loop_nest_depth_i, // [RL13] [RL14]
                            cfg_q[7:0]};

   // ***************************************************
   // accumulator status flags
   // ***************************************************
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         guard_a_q <= 1'b0;
         guard_b_q <= 1'b0;
         clip_a_q  <= 1'b0;
         clip_b_q  <= 1'b0;
      end
      else
      begin
         if (acc_evt_i.valid)
         begin
            guard_a_q <= acc_evt_i.guard_a; // [RL1]
            guard_b_q <= acc_evt_i.guard_b;
         end
         if (acc_evt_i.valid && acc_evt_i.clip_a)
            clip_a_q <= 1'b1; // [RL2]
         else if (clr_clip_a)
            clip_a_q <= 1'b0;
         if (acc_evt_i.valid && acc_evt_i.clip_b)
            clip_b_q <= 1'b1; // [RL2]
         else if (clr_clip_b)
            clip_b_q <= 1'b0;
      end
   end

   // ***************************************************
   // alu flags and priority field
   // ***************************************************
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         half_c_q   <= 1'b0;
         neg_q      <= 1'b0;
         sign_chg_q <= 1'b0;
         zero_q     <= 1'b0;
         carry_q    <= 1'b0;
         prio_q     <= 3'h0;
      end
      else
      begin
         if (alu_upd)
         begin
            half_c_q   <= alu_res_o.half_carry; // [RL5] [RL23]
            neg_q      <= alu_res_o.neg; // [RL8]
            sign_chg_q <= alu_res_o.sign_chg; // [RL9]
            zero_q     <= alu_res_o.zero; // [RL10]
            carry_q    <= alu_res_o.carry; // [RL11]
         end
         else if (wr_flag)
         begin
            half_c_q   <= wdata_i[FW_HALF_C];
            neg_q      <= wdata_i[FW_NEG];
            sign_chg_q <= wdata_i[FW_SIGN_CHG];
            zero_q     <= wdata_i[FW_ZERO];
            carry_q    <= wdata_i[FW_CARRY];
         end
         if (wr_flag && !nest_dis)
            prio_q <= wdata_i[FW_PRIO_LO +: 3]; // [RL7]
      end
   end

   // ***************************************************
   // config word, interrupt control copy, early exit
   // ***************************************************
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cfg_q   <= CFG_WORD_RST; // [RL16]
         ictl_q  <= INT_CTRL_RST;
         early_q <= 1'b0;
      end
      else
      begin
         early_q <= early_req; // [RL13]
         if (wr_cfg)
         begin
            cfg_q[CW_MUL_US] <= wdata_i[CW_MUL_US];
            cfg_q[7:4]       <= wdata_i[7:4];
            cfg_q[2:0]       <= wdata_i[2:0];
            if (!wdata_i[CW_PRIO_MSB])
               cfg_q[CW_PRIO_MSB] <= 1'b0; // [RL6]
         end
         if (wr_ictl)
            ictl_q <= {wdata_i[IC_NEST_DIS], 15'h0000};
      end
   end

   // ***************************************************
   // shared 17x17 multiplier
   // ***************************************************
   logic               sa, sb;
   logic signed [16:0] ma, mb;
   logic signed [33:0] pr;
   always_comb
   begin
      sa = 1'b0;
      sb = 1'b0;
      ma = 17'sh00000;
      mb = 17'sh00000;
      case (mul_form_i)
         CFC_MUL_SS:
         begin
            sa = 1'b1;
            sb = 1'b1;
         end
         CFC_MUL_SU:   sa = 1'b1;
         CFC_MUL_US:   sb = 1'b1;
         CFC_MUL_SLIT: sa = 1'b1;
         default:      sa = 1'b0;
      endcase
      ma = {sa & mul_a_i[15], mul_a_i};
      mb = {sb & mul_b_i[15], mul_b_i};
      if (mul_form_i == CFC_MUL_SLIT || mul_form_i == CFC_MUL_ULIT)
         mb = {12'h000, mul_b_i[4:0]};
      if (mul_form_i == CFC_MUL_BYTE)
      begin
         ma = {9'h000, mul_a_i[7:0]};
         mb = {9'h000, mul_b_i[7:0]};
      end
      pr = ma * mb; // [RL22]
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         prod_q <= 32'h00000000;
      else if (mul_valid_i)
         prod_q <= pr[31:0];
   end

   // ***************************************************
   // register read port
   // ***************************************************
   wire [15:0] rd_mux = (addr_i == ADDR_FLAG_WORD) ? flag_word :
                        (addr_i == ADDR_CFG_WORD)  ? cfg_word  :
                        (addr_i == ADDR_INT_CTRL)  ? ictl_q    : 16'h0000;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_q <= 16'h0000;
      else if (rd_i)
         rdata_q <= rd_mux;
   end

   // ***************************************************
   // outputs
   // ***************************************************
   assign rdata_o                 = rdata_q;
   assign mul_prod_o              = prod_q;
   assign early_loop_exit_o       = early_q; // [RL13]
   assign cpu_priority_level_o    = {cfg_q[CW_PRIO_MSB], prio_q}; // [RL6]
   assign user_irq_masked_o       = cfg_q[CW_PRIO_MSB] || (prio_q == PRIO_ALL_MASK); // [RL6]
   assign mult_unsigned_sel_o     = cfg_q[CW_MUL_US]; // [RL12]
   assign acc_a_clip_enable_o     = cfg_q[CW_CLIP_A]; // [RL15]
   assign acc_b_clip_enable_o     = cfg_q[CW_CLIP_B]; // [RL15]
   assign store_clip_enable_o     = cfg_q[CW_STORE]; // [RL16]
   assign clip_width_select_o     = cfg_q[CW_WIDTH]; // [RL17]
   assign program_window_enable_o = cfg_q[CW_PROG_WIN]; // [RL18]
   assign rounding_select_o       = cfg_q[CW_ROUND]; // [RL19]
   assign int_mode_o              = cfg_q[CW_INT_MODE]; // [RL20]

   // ***************************************************
   // checks
   // ***************************************************
   a_clip_sticky_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RL2]
      $past(clip_a_q) && !$past(clr_clip_a) |-> clip_a_q)
      else $error("clip flag a dropped without clear");
   a_clip_set_wins: assert property (@(posedge clk_i) disable iff (rst_i) // [RL2]
      acc_evt_i.valid && acc_evt_i.clip_b |=> clip_b_q)
      else $error("clip flag b not set");
   a_any_clip_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RL3]
      clr_any_clip && !acc_evt_i.valid |=> !clip_a_q && !clip_b_q)
      else $error("combined clear missed a flag");
   a_prio_locked: assert property (@(posedge clk_i) disable iff (rst_i) // [RL7]
      nest_dis |=> $stable(prio_q))
      else $error("priority changed while locked");
   a_zero_follow: assert property (@(posedge clk_i) disable iff (rst_i) // [RL10]
      alu_upd |=> zero_q == $past(alu_res_o.zero))
      else $error("zero flag wrong");
   a_carry_alu_wins: assert property (@(posedge clk_i) disable iff (rst_i) // [RL23]
      alu_upd && wr_flag |=> carry_q == $past(alu_res_o.carry))
      else $error("write beat alu carry");
   a_early_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // [RL13]
      early_req |=> early_loop_exit_o ##1 (early_loop_exit_o == $past(early_req)))
      else $error("early exit pulse wrong");
   a_prio_msb_noset: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
      !cfg_q[CW_PRIO_MSB] |=> !cfg_q[CW_PRIO_MSB])
      else $error("priority msb was set");
   a_irq_mask: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
      prio_q == PRIO_ALL_MASK |-> user_irq_masked_o)
      else $error("user interrupts not masked");

endmodule : cfc_core

// ==== testbench/cfc_core_test.sv ====
// testbench: register port, alu flags, accumulator status and multiplier of cfc_core
`timescale 1ns/1ps
module cfc_core_test
   import cfc_pkg::*;
();
   logic         clk_i, rst_i, wr_i, rd_i, do_running_i, rep_running_i, mul_valid_i;
   logic [1:0]   addr_i;
   logic [15:0]  wdata_i, rdata_o, mul_a_i, mul_b_i, rv;
   logic [2:0]   loop_nest_depth_i;
   cfc_alu_req_t alu_req_i;
   cfc_alu_res_t alu_res_o, er;
   cfc_acc_evt_t acc_evt_i;
   cfc_mul_t     mul_form_i;
   logic [31:0]  mul_prod_o;
   logic         early_loop_exit_o, user_irq_masked_o, mult_unsigned_sel_o, acc_a_clip_enable_o;
   logic         acc_b_clip_enable_o, store_clip_enable_o, clip_width_select_o, program_window_enable_o;
   logic         rounding_select_o, int_mode_o;
   logic [3:0]   cpu_priority_level_o;
   logic [7:0]   cfg_outs;
   int           fails, samples_checked;
   int           bp [8] = '{12, 7, 6, 5, 4, 2, 1, 0};

   assign cfg_outs = {mult_unsigned_sel_o, acc_a_clip_enable_o, acc_b_clip_enable_o, store_clip_enable_o,
                      clip_width_select_o, program_window_enable_o, rounding_select_o, int_mode_o};

   cfc_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .alu_req_i(alu_req_i), .alu_res_o(alu_res_o), .acc_evt_i(acc_evt_i),
      .do_running_i(do_running_i), .rep_running_i(rep_running_i), .loop_nest_depth_i(loop_nest_depth_i),
      .mul_valid_i(mul_valid_i), .mul_form_i(mul_form_i), .mul_a_i(mul_a_i), .mul_b_i(mul_b_i),
      .mul_prod_o(mul_prod_o), .early_loop_exit_o(early_loop_exit_o), .user_irq_masked_o(user_irq_masked_o),
      .cpu_priority_level_o(cpu_priority_level_o), .mult_unsigned_sel_o(mult_unsigned_sel_o),
      .acc_a_clip_enable_o(acc_a_clip_enable_o), .acc_b_clip_enable_o(acc_b_clip_enable_o),
      .store_clip_enable_o(store_clip_enable_o), .clip_width_select_o(clip_width_select_o),
      .program_window_enable_o(program_window_enable_o), .rounding_select_o(rounding_select_o),
      .int_mode_o(int_mode_o));

   // ***************************************************
   // bus tasks and compare
   // ***************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
      #1;
   endtask : reg_wr

   task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1;
      d = rdata_o;
   endtask : reg_rd

   task automatic rd_chk(input logic [1:0] a, input logic [15:0] exp, input string what);
      reg_rd(a, rv);
      check(32'(rv), 32'(exp), what);
   endtask : rd_chk

   task automatic acc_ev(input logic ga, input logic gb, input logic ca, input logic cb);
      @(posedge clk_i);
      acc_evt_i <= cfc_acc_evt_t'({1'b1, ga, gb, ca, cb});
      @(posedge clk_i);
      acc_evt_i <= '0;
   endtask : acc_ev

   function automatic cfc_alu_res_t alu_model(cfc_op_t op, logic bm, logic [15:0] a, logic [15:0] b);
      logic [15:0]  m, bb;
      logic [16:0]  s;
      logic         ci;
      int           w;
      cfc_alu_res_t r;
      w  = bm ? 8 : 16;
      m  = bm ? 16'h00FF : 16'hFFFF;
      ci = (op == CFC_OP_SUB);
      bb = ci ? (~b & m) : (b & m);
      s  = 17'(a & m) + 17'(bb) + 17'(ci);
      r  = '0;
      case (op)
         CFC_OP_ADD, CFC_OP_SUB:
         begin
            r.result     = s[15:0] & m;
            r.carry      = s[w];
            r.half_carry = bm ? ((5'(a[3:0]) + 5'(bb[3:0]) + 5'(ci)) >> 4) != 0
                              : ((9'(a[7:0]) + 9'(bb[7:0]) + 9'(ci)) >> 8) != 0;
            r.sign_chg   = (a[w-1] == bb[w-1]) && (r.result[w-1] != a[w-1]);
         end
         CFC_OP_AND: r.result = a & b & m;
         CFC_OP_OR:  r.result = (a | b) & m;
         CFC_OP_SHL: {r.carry, r.result} = {a[w-1], (a << 1) & m};
         CFC_OP_SHR: {r.carry, r.result} = {a[0], (a & m) >> 1};
         CFC_OP_ASR: {r.carry, r.result} = {a[0], ((a & m) >> 1) | (a & (m ^ (m >> 1)))};
         default:    r.result = (a ^ b) & m;
      endcase
      r.neg  = r.result[w-1];
      r.zero = (r.result == 16'h0000);
      return r;
   endfunction : alu_model

   task automatic alu_do(input cfc_op_t op, input logic bm, input logic [15:0] a, input logic [15:0] b);
      er = alu_model(op, bm, a, b);
      @(posedge clk_i);
      alu_req_i <= '{valid: 1'b1, op: op, byte_mode: bm, a: a, b: b};
      #1;
      check(32'(alu_res_o.result), 32'(er.result), "alu result");
      @(posedge clk_i);
      alu_req_i <= '0;
      rd_chk(ADDR_FLAG_WORD, {7'h0, er.half_carry, 4'h0, er.neg, er.sign_chg, er.zero, er.carry},
             "alu flags");
   endtask : alu_do

   task automatic mul_do(input cfc_mul_t f, input logic [15:0] a, input logic [15:0] b, input logic [31:0] e);
      @(posedge clk_i);
      mul_valid_i <= 1'b1;
      mul_form_i  <= f;
      mul_a_i     <= a;
      mul_b_i     <= b;
      @(posedge clk_i);
      mul_valid_i <= 1'b0;
      #1;
      check(mul_prod_o, e, "product");
   endtask : mul_do

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   // ***************************************************
   // clock, watchdog and test sequence
   // ***************************************************
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   initial
   begin
      repeat (20000) @(posedge clk_i);
      fails++;
      $display("BAD t=%0t watchdog expired", $time);
      print_verdict();
   end

   initial
   begin
      rst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 2'h0;
      wdata_i = 16'h0000;
      alu_req_i = '0;
      acc_evt_i = '0;
      do_running_i = 1'b0;
      rep_running_i = 1'b0;
      loop_nest_depth_i = 3'h0;
      mul_valid_i = 1'b0;
      mul_form_i = CFC_MUL_SS;
      mul_a_i = 16'h0000;
      mul_b_i = 16'h0000;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(ADDR_FLAG_WORD, 16'h0000, "flag reset");
      rd_chk(ADDR_CFG_WORD, 16'h0020, "cfg reset");
      check(32'(store_clip_enable_o), 32'h1, "store clip reset");
      $display("test reset done");

      loop_nest_depth_i <= 3'h7;
      reg_wr(ADDR_CFG_WORD, 16'hFFFF);
      check(32'(early_loop_exit_o), 32'h1, "early exit pulse");
      @(posedge clk_i);
      #1;
      check(32'(early_loop_exit_o), 32'h0, "early exit ends");
      check(32'(cpu_priority_level_o[3]), 32'h0, "prio msb set by write");
      rd_chk(ADDR_CFG_WORD, 16'h17F7, "cfg ro bits");
      for (int i = 0; i < 8; i++)
      begin
         reg_wr(ADDR_CFG_WORD, 16'h0001 << bp[i]);
         check(32'(cfg_outs), 32'(8'h80 >> i), "cfg level");
         rd_chk(ADDR_CFG_WORD, (16'h0001 << bp[i]) | 16'h0700, "cfg readback");
      end
      check(32'(early_loop_exit_o), 32'h0, "no early exit on zero");
      reg_wr(2'h3, 16'hFFFF);
      rd_chk(2'h3, 16'h0000, "unmapped read");
      rd_chk(ADDR_CFG_WORD, 16'h0701, "cfg after unmapped");
      $display("test config done");

      reg_wr(ADDR_FLAG_WORD, 16'h00C0);
      check(32'({user_irq_masked_o, cpu_priority_level_o}), 32'h06, "prio 6");
      reg_wr(ADDR_FLAG_WORD, 16'h00E0);
      check(32'({user_irq_masked_o, cpu_priority_level_o}), 32'h17, "prio 7 masks");
      reg_wr(ADDR_INT_CTRL, 16'h8000);
      rd_chk(ADDR_INT_CTRL, 16'h8000, "nest disable");
      reg_wr(ADDR_FLAG_WORD, 16'h0000);
      rd_chk(ADDR_FLAG_WORD, 16'h00E0, "prio locked");
      reg_wr(ADDR_INT_CTRL, 16'h0000);
      reg_wr(ADDR_FLAG_WORD, 16'h0000);
      rd_chk(ADDR_FLAG_WORD, 16'h0000, "prio unlocked");
      $display("test priority done");

      do_running_i  <= 1'b1;
      rep_running_i <= 1'b1;
      reg_wr(ADDR_FLAG_WORD, 16'h0000);
      rd_chk(ADDR_FLAG_WORD, 16'h0210, "loops running");
      do_running_i  <= 1'b0;
      rd_chk(ADDR_FLAG_WORD, 16'h0010, "repeat only");
      rep_running_i <= 1'b0;
      $display("test loops done");

      acc_ev(1'b1, 1'b0, 1'b1, 1'b0);
      rd_chk(ADDR_FLAG_WORD, 16'hAC00, "guard a clip a");
      acc_ev(1'b0, 1'b1, 1'b0, 1'b0);
      rd_chk(ADDR_FLAG_WORD, 16'h6C00, "guard b clip sticky");
      reg_wr(ADDR_FLAG_WORD, 16'hFFFF);
      rd_chk(ADDR_FLAG_WORD, 16'h6DEF, "write all ones");
      reg_wr(ADDR_FLAG_WORD, 16'h0400);
      rd_chk(ADDR_FLAG_WORD, 16'h4800, "clear clip a");
      acc_ev(1'b0, 1'b0, 1'b1, 1'b1);
      rd_chk(ADDR_FLAG_WORD, 16'h3400, "both clip");
      reg_wr(ADDR_FLAG_WORD, 16'h3000);
      rd_chk(ADDR_FLAG_WORD, 16'h0000, "any clip clear");
      reg_wr(ADDR_FLAG_WORD, 16'hFC00);
      rd_chk(ADDR_FLAG_WORD, 16'h0000, "clip never set");
      $display("test accumulator done");

      alu_do(CFC_OP_ADD, 1'b0, 16'h7FFF, 16'h0001);
      alu_do(CFC_OP_ADD, 1'b0, 16'hFFFF, 16'h0001);
      alu_do(CFC_OP_SUB, 1'b0, 16'h0000, 16'h0001);
      alu_do(CFC_OP_SUB, 1'b0, 16'h8000, 16'h0001);
      alu_do(CFC_OP_ADD, 1'b1, 16'h120F, 16'h3401);
      alu_do(CFC_OP_SUB, 1'b1, 16'h5680, 16'h7801);
      alu_do(CFC_OP_AND, 1'b0, 16'hF0F0, 16'h0FF0);
      alu_do(CFC_OP_OR, 1'b0, 16'h8000, 16'h0001);
      alu_do(CFC_OP_XOR, 1'b0, 16'hAAAA, 16'hAAAA);
      alu_do(CFC_OP_SHL, 1'b0, 16'h8001, 16'h0000);
      alu_do(CFC_OP_SHR, 1'b1, 16'h1281, 16'h0000);
      alu_do(CFC_OP_ASR, 1'b1, 16'h0081, 16'h0000);
      @(posedge clk_i);
      addr_i    <= ADDR_FLAG_WORD;
      wdata_i   <= 16'h0000;
      wr_i      <= 1'b1;
      alu_req_i <= '{valid: 1'b1, op: CFC_OP_ADD, byte_mode: 1'b0, a: 16'hFFFF, b: 16'h0001};
      @(posedge clk_i);
      wr_i      <= 1'b0;
      alu_req_i <= '0;
      rd_chk(ADDR_FLAG_WORD, 16'h0103, "alu beats write");
      $display("test alu done");

      mul_do(CFC_MUL_SS, 16'hFFFF, 16'h0002, 32'hFFFFFFFE);
      mul_do(CFC_MUL_SS, 16'h8000, 16'h8000, 32'h40000000);
      mul_do(CFC_MUL_UU, 16'hFFFF, 16'h0002, 32'h0001FFFE);
      mul_do(CFC_MUL_US, 16'h1234, 16'h0010, 32'h00012340);
      mul_do(CFC_MUL_SU, 16'h1234, 16'h0010, 32'h00012340);
      mul_do(CFC_MUL_SLIT, 16'h8000, 16'h001F, 32'hFFF08000);
      mul_do(CFC_MUL_ULIT, 16'h8000, 16'h001F, 32'h000F8000);
      mul_do(CFC_MUL_BYTE, 16'h12FF, 16'h34FF, 32'h0000FE01);
      $display("test multiply done");
      print_verdict();
   end
endmodule : cfc_core_test
